// ===== rtl/tern_pkg.sv
// Constants and shared encode and decode functions for the ternary master.
// Assumes a single 40 MHz clock and pins synchronous to that clock.
// ****************************************************************
// What the document requires of master and slave
// R1: Symbol bit 1 is clock XNOR previous clock, bit 0 data XNOR previous.
// R2: Pure mode gathers twelve symbols, six pairs, and uses every one.
// R3: Legacy mode drops symbol 01 seen with clock Low, until twelve kept.
// R4: Adjacent symbols pair as threes and ones digit into one triplet.
// R5: Pair 2,2 of value eight is an invalid pair.
// R6: Six triplets in arrival order form the 18-bit word.
// R7: Parity occupies the two low bits, odd-index bit above even-index.
// R8: Odd parity is XOR of odd data bits, even of even data bits.
// R9: Both parity bits are checked, then stripped to leave 16 data bits.
// R10: After entry or restart, master first sends a normal command word.
// R11: Command bit 15 set means read, clear means write.
// R12: Bits 14:8 hold the command code; 00-7F write, 80-FF read.
// R13: Bits 7:1 hold the target dynamic address; bit 0 reserved.
// R14: First command line change waits one symbol, at least 32 ns.
// R15: Slave uses first change as first symbol, reference data High clock Low.
// R16: After restart validation, master drives one more clock falling edge.
// R17: For reads master parks both lines High in one edge, then releases.
// R18: A refusing slave still takes the lines, then ends at once.
// R19: Slave ends a read only after a whole word, or instead of any.
// R20: Slave first sets clock Low, data High unless already so.
// R21: Three symbol 2 in a row with clock Low mean handover.
// R22: After the third symbol 2 the slave releases both lines.
// R23: Seeing data Low after handover, master drives both lines Low.
// R24: Parity and invalid-pair failures are flagged to the control logic.
// R25: Each recovered word comes with a one-cycle valid strobe.
// ****************************************************************
package tern_pkg;

	// ************************************************************
	// Timing
	// ************************************************************
	localparam int CLK_MHZ       = 40;
	localparam int SYM_MIN_NS    = 32;
	localparam int SYM_MIN_CYC   = (SYM_MIN_NS * CLK_MHZ + 999) / 1000;
	localparam int DIV_W         = 8;

	// ************************************************************
	// Word and symbol layout
	// ************************************************************
	localparam int DATA_BITS     = 16;
	localparam int WORD_BITS     = 18;
	localparam int SYMS_PER_WORD = 12;
	localparam int HANDOVER_TWOS = 3;
	localparam int FIFO_DEPTH    = 16;
	localparam logic [1:0] SYM_DUMMY = 2'h1;
	localparam logic [1:0] SYM_TWO   = 2'h2;
	localparam logic [3:0] LAST_SYM  = 4'hb;
	localparam logic [1:0] TWOS_DONE = 2'h3;
	localparam logic       REF_SCL   = 1'b0;
	localparam logic       REF_SDA   = 1'b1;

	// ************************************************************
	// Command word fields
	// ************************************************************
	localparam int CMD_DIR_BIT   = 15;
	localparam int CMD_CODE_MSB  = 14;
	localparam int CMD_CODE_LSB  = 8;
	localparam int CMD_ADDR_MSB  = 7;
	localparam int CMD_ADDR_LSB  = 1;
	localparam logic CMD_RSVD    = 1'b0;

	// Parity pair: odd-index bit above even-index bit
	function automatic logic [1:0] parity2(input logic [15:0] d);
		logic odd_parity_bit;
		logic even_parity_bit;
		odd_parity_bit  = 1'b0;
		even_parity_bit = 1'b0;
		for (int i = 0; i < DATA_BITS; i = i + 2) begin
			even_parity_bit = even_parity_bit ^ d[i];
			odd_parity_bit  = odd_parity_bit ^ d[i+1];
		end
		return {odd_parity_bit, even_parity_bit};
	endfunction : parity2

	// Pair to triplet; bit 3 of the result flags a value above seven
	function automatic logic [3:0] pair_to_trip(input logic [1:0] hi,
		input logic [1:0] lo);
		logic [3:0] v;
		v = {1'b0, hi, 1'b0} + {2'b00, hi} + {2'b00, lo};
		return v;
	endfunction : pair_to_trip

	// Triplet to pair of ternary digits {high, low}
	function automatic logic [3:0] trip_to_pair(input logic [2:0] t);
		logic [1:0] hi;
		logic [2:0] m;
		logic [2:0] r;
		hi = (t >= 3'h6) ? 2'h2 : ((t >= 3'h3) ? 2'h1 : 2'h0);
		m  = {hi, 1'b0} + {1'b0, hi};
		r  = t - m;
		return {hi, r[1:0]};
	endfunction : trip_to_pair

endpackage : tern_pkg

// ===== rtl/tern_fifo.sv
// Flip-flop FIFO with valid and ready on both sides.
// Assumes one clock and an asynchronous active-low reset from the parent.
module tern_fifo #(
	parameter int W     = 16,
	parameter int DEPTH = 16
) (
	input  wire logic         clock,
	input  wire logic         rst_n,
	input  wire logic         in_valid,
	output logic              in_ready,
	input  wire logic [W-1:0] in_data,
	output logic              out_valid,
	input  wire logic         out_ready,
	output logic [W-1:0]      out_data
);
	localparam int AW = $clog2(DEPTH);

	typedef struct packed {
		logic [DEPTH-1:0][W-1:0] mem;
		logic [AW-1:0]           wp;
		logic [AW-1:0]           rp;
		logic [AW:0]             cnt;
	} fifo_t;

	fifo_t s_ff;
	fifo_t nxt_s;
	logic  push;
	logic  pop;

	assign in_ready  = (s_ff.cnt != DEPTH[AW:0]);
	assign out_valid = (s_ff.cnt != '0);
	assign out_data  = s_ff.mem[s_ff.rp];
	assign push      = in_valid && in_ready;
	assign pop       = out_valid && out_ready;

	always_comb begin
		nxt_s = s_ff;
		if (push) begin
			nxt_s.mem[s_ff.wp] = in_data;
			nxt_s.wp = (s_ff.wp == AW'(DEPTH - 1)) ? '0 : s_ff.wp + 1'b1;
		end
		if (pop) begin
			nxt_s.rp = (s_ff.rp == AW'(DEPTH - 1)) ? '0 : s_ff.rp + 1'b1;
		end
		nxt_s.cnt = s_ff.cnt + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			s_ff <= '0;
		end else begin
			s_ff <= nxt_s;
		end
	end
endmodule : tern_fifo

// ===== rtl/tern_word_decoder.sv
// Symbol stream to 16-bit word decoder with parity and pair checks.
// Assumes symbols arrive as one-cycle strobes with the clock level after.
module tern_word_decoder
	import tern_pkg::*;
(
	input  wire logic        clock,
	input  wire logic        rst_n,
	input  wire logic        clear,
	input  wire logic        ternary_legacy_tolerant_mode,
	input  wire logic        sym_valid,
	input  wire logic [1:0]  sym,
	input  wire logic        scl_now,
	output logic             word_valid,
	output logic [15:0]      word,
	output logic             parity_err,
	output logic             pair_err
);
	typedef struct packed {
		logic [3:0]  n;
		logic [1:0]  high_ternary_digit;
		logic [14:0] acc;
		logic        bad;
		logic [15:0] word;
		logic        vld;
		logic        perr;
		logic        ierr;
	} dec_t;

	dec_t s_ff;
	dec_t nxt_s;
	logic keep;
	logic [3:0] trip;
	logic [17:0] full;

	assign word_valid = s_ff.vld;
	assign word       = s_ff.word;
	assign parity_err = s_ff.perr;
	assign pair_err   = s_ff.ierr;

	always_comb begin
		nxt_s = s_ff;
		nxt_s.vld  = 1'b0;
		nxt_s.perr = 1'b0;
		nxt_s.ierr = 1'b0;
		keep = sym_valid && !(ternary_legacy_tolerant_mode &&
			sym == SYM_DUMMY && !scl_now); // see R3
		trip = pair_to_trip(s_ff.high_ternary_digit, sym); // see R4
		full = {s_ff.acc, trip[2:0]}; // see R6
		if (clear) begin
			nxt_s.n   = '0;
			nxt_s.bad = 1'b0;
		end else if (keep) begin
			nxt_s.n = s_ff.n + 1'b1;
			if (!s_ff.n[0]) begin
				nxt_s.high_ternary_digit = sym;
			end else begin
				nxt_s.acc = {s_ff.acc[11:0], trip[2:0]};
				nxt_s.bad = s_ff.bad | trip[3]; // see R5
			end
			if (s_ff.n == LAST_SYM) begin // see R2
				nxt_s.n    = '0;
				nxt_s.bad  = 1'b0;
				nxt_s.word = full[17:2]; // see R9
				nxt_s.vld  = 1'b1; // see R25
				nxt_s.perr = parity2(full[17:2]) != full[1:0]; // see R7, R8
				nxt_s.ierr = s_ff.bad | trip[3]; // see R24
			end
		end
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			s_ff <= '0;
		end else begin
			s_ff <= nxt_s;
		end
	end
endmodule : tern_word_decoder

// ===== rtl/tern_master.sv
// Ternary link master: sends the command word, turns the bus round for
// reads, recovers the slave's words into a FIFO and takes the bus back.
// Assumes pins are synchronous to clock and the entry pulse is external.
module tern_master
	import tern_pkg::*;
#(
	parameter int SYM_CYC = tern_pkg::SYM_MIN_CYC,
	parameter int DEPTH   = tern_pkg::FIFO_DEPTH
) (
	input  wire logic        clock,
	input  wire logic        rstn,
	input  wire logic        cmd_start,
	input  wire logic        cmd_restart,
	input  wire logic        ternary_legacy_tolerant_mode,
	input  wire logic        cmd_read,
	input  wire logic [6:0]  cmd_code,
	input  wire logic [6:0]  cmd_addr,
	output logic             cmd_ready,
	output logic             done,
	output logic             rd_valid,
	input  wire logic        rd_ready,
	output logic [15:0]      rd_data,
	output logic             parity_err,
	output logic             pair_err,
	output logic             overflow,
	input  wire logic        scl_i,
	output logic             scl_o,
	output logic             scl_oe_n,
	input  wire logic        sda_i,
	output logic             sda_o,
	output logic             sda_oe_n
);
	// ************************************************************
	// Types and state
	// ************************************************************
	typedef enum logic [6:0] {
		ST_IDLE  = 7'b000_0001,
		ST_PHI   = 7'b000_0010,
		ST_HOLD  = 7'b000_0100,
		ST_TX    = 7'b000_1000,
		ST_PARK  = 7'b001_0000,
		ST_RX    = 7'b010_0000,
		ST_TAKE  = 7'b100_0000
	} state_t;

	typedef struct packed {
		state_t      st;
		logic [DIV_W-1:0] div;
		logic [23:0] syms;
		logic [3:0]  nsym;
		logic        rd;
		logic        scl;
		logic        sda;
		logic        scl_oe_n;
		logic        sda_oe_n;
		logic        ref_scl;
		logic        ref_sda;
		logic [1:0]  twos;
		logic        dclr;
		logic        done;
		logic        ready;
		logic        perr;
		logic        ierr;
		logic        ovf;
	} mst_t;

	mst_t s_ff;
	mst_t nxt_s;

	// ************************************************************
	// Reset release
	// ************************************************************
	logic [1:0] rst_sync_ff;
	logic       rst_n;

	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			rst_sync_ff <= 2'b00;
		end else begin
			rst_sync_ff <= {rst_sync_ff[0], 1'b1};
		end
	end
	assign rst_n = rst_sync_ff[1];

	// ************************************************************
	// Helpers
	// ************************************************************
	localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(SYM_CYC - 1);

	// Encode the 18-bit word into twelve symbols, first symbol on top
	function automatic logic [23:0] word_syms(input logic [15:0] d);
		logic [17:0] w;
		logic [23:0] r;
		logic [3:0]  p;
		w = {d, parity2(d)};
		r = '0;
		for (int i = 0; i < 6; i++) begin
			p = trip_to_pair(w[17-3*i -: 3]);
			r[23-4*i -: 4] = p;
		end
		return r;
	endfunction : word_syms

	logic        tick;
	logic [15:0] cmd_word;
	logic        changed;
	logic [1:0]  rx_sym;
	logic        dec_valid;
	logic [15:0] dec_word;
	logic        dec_perr;
	logic        dec_ierr;
	logic        fifo_in_ready;
	logic        fifo_out_valid;
	logic [15:0] fifo_out_data;

	assign tick = (s_ff.div == DIV_LAST);

	always_comb begin
		cmd_word = '0;
		cmd_word[CMD_DIR_BIT] = cmd_read; // see R11
		cmd_word[CMD_CODE_MSB:CMD_CODE_LSB] = cmd_code; // see R12
		cmd_word[CMD_ADDR_MSB:CMD_ADDR_LSB] = cmd_addr; // see R13
		cmd_word[0] = CMD_RSVD;
	end

	// Received symbol from line changes against the held reference
	assign changed = (scl_i != s_ff.ref_scl) || (sda_i != s_ff.ref_sda);
	assign rx_sym  = {~(scl_i ^ s_ff.ref_scl),
		~(sda_i ^ s_ff.ref_sda)}; // see R1

	// ************************************************************
	// Sequencer
	// ************************************************************
	always_comb begin
		nxt_s = s_ff;
		nxt_s.done = 1'b0;
		nxt_s.dclr = 1'b0;
		nxt_s.perr = dec_perr;
		nxt_s.ierr = dec_ierr;
		nxt_s.ovf  = dec_valid && !fifo_in_ready;
		nxt_s.div  = tick ? '0 : s_ff.div + 1'b1;
		unique case (s_ff.st)
			ST_IDLE: begin
				nxt_s.div = '0;
				// New command needs an empty FIFO so a read starts with all DEPTH entries free
				nxt_s.ready = !fifo_out_valid;
				if (cmd_start && s_ff.ready) begin
					nxt_s.ready    = 1'b0;
					nxt_s.syms     = word_syms(cmd_word); // see R10
					nxt_s.rd       = cmd_read;
					nxt_s.nsym     = '0;
					nxt_s.scl_oe_n = 1'b0;
					nxt_s.sda_oe_n = 1'b0;
					nxt_s.sda      = REF_SDA;
					if (cmd_restart) begin
						nxt_s.scl = 1'b1;
						nxt_s.st  = ST_PHI;
					end else begin
						// Entry pulse has just fallen outside this block
						nxt_s.scl = REF_SCL;
						nxt_s.st  = ST_HOLD;
					end
				end
			end
			ST_PHI: begin
				if (tick) begin
					nxt_s.scl = REF_SCL; // see R16
					nxt_s.st  = ST_HOLD;
				end
			end
			ST_HOLD: begin
				if (tick) begin
					nxt_s.st = ST_TX; // see R14
				end
			end
			ST_TX: begin
				if (tick) begin
					if (s_ff.nsym == SYMS_PER_WORD[3:0]) begin
						if (s_ff.rd) begin
							// Single edge to High: only lines now Low move
							nxt_s.scl = 1'b1; // see R17
							nxt_s.sda = 1'b1;
							nxt_s.st  = ST_PARK;
						end else begin
							nxt_s.done = 1'b1;
							nxt_s.st   = ST_IDLE;
						end
					end else if (ternary_legacy_tolerant_mode && s_ff.scl &&
						s_ff.syms[23:22] != 2'b00) begin
						nxt_s.scl = 1'b0;
					end else begin
						nxt_s.scl  = s_ff.scl ^ ~s_ff.syms[23];
						nxt_s.sda  = s_ff.sda ^ ~s_ff.syms[22];
						nxt_s.syms = {s_ff.syms[21:0], 2'b00};
						nxt_s.nsym = s_ff.nsym + 1'b1;
					end
				end
			end
			ST_PARK: begin
				if (tick) begin
					nxt_s.scl_oe_n = 1'b1; // see R17
					nxt_s.sda_oe_n = 1'b1;
					nxt_s.ref_scl  = 1'b1;
					nxt_s.ref_sda  = 1'b1;
					nxt_s.twos     = '0;
					nxt_s.dclr     = 1'b1;
					nxt_s.st       = ST_RX;
				end
			end
			ST_RX: begin
				nxt_s.div = '0;
				if (changed) begin
					nxt_s.ref_scl = scl_i;
					nxt_s.ref_sda = sda_i;
					if (rx_sym == SYM_TWO && !scl_i) begin
						nxt_s.twos = s_ff.twos + 1'b1; // see R21
					end else begin
						nxt_s.twos = '0;
					end
					if (rx_sym == SYM_TWO && !scl_i &&
						s_ff.twos == TWOS_DONE - 2'h1) begin
						// Handover: partial symbols are pattern, not data
						nxt_s.dclr = 1'b1; // see R19, R18
						nxt_s.st   = ST_TAKE;
					end
				end
			end
			ST_TAKE: begin
				nxt_s.div = '0;
				if (!sda_i) begin
					nxt_s.scl      = 1'b0; // see R23
					nxt_s.sda      = 1'b0;
					nxt_s.scl_oe_n = 1'b0;
					nxt_s.sda_oe_n = 1'b0;
					nxt_s.done     = 1'b1;
					nxt_s.st       = ST_IDLE;
				end
			end
			default: begin
				nxt_s.st = ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			s_ff          <= '0;
			s_ff.st       <= ST_IDLE;
			s_ff.scl      <= 1'b1;
			s_ff.sda      <= 1'b1;
			s_ff.scl_oe_n <= 1'b1;
			s_ff.sda_oe_n <= 1'b1;
			s_ff.ref_scl  <= REF_SCL;
			s_ff.ref_sda  <= REF_SDA;
		end else begin
			s_ff <= nxt_s;
		end
	end

	// ************************************************************
	// Receive path
	// ************************************************************
	tern_word_decoder u_dec (
		.clock                        (clock),
		.rst_n                        (rst_n),
		.clear                        (nxt_s.dclr),
		.ternary_legacy_tolerant_mode (ternary_legacy_tolerant_mode),
		.sym_valid                    (s_ff.st == ST_RX && changed),
		.sym                          (rx_sym),
		.scl_now                      (scl_i),
		.word_valid                   (dec_valid),
		.word                         (dec_word),
		.parity_err                   (dec_perr),
		.pair_err                     (dec_ierr)
	);

	tern_fifo #(
		.W     (DATA_BITS),
		.DEPTH (DEPTH)
	) u_fifo (
		.clock     (clock),
		.rst_n     (rst_n),
		.in_valid  (dec_valid),
		.in_ready  (fifo_in_ready),
		.in_data   (dec_word),
		.out_valid (fifo_out_valid),
		.out_ready (rd_ready),
		.out_data  (fifo_out_data)
	);

	// ************************************************************
	// Outputs
	// ************************************************************
	assign scl_o      = s_ff.scl;
	assign sda_o      = s_ff.sda;
	assign scl_oe_n   = s_ff.scl_oe_n;
	assign sda_oe_n   = s_ff.sda_oe_n;
	assign cmd_ready  = s_ff.ready;
	assign done       = s_ff.done;
	assign parity_err = s_ff.perr; // see R24
	assign pair_err   = s_ff.ierr;
	assign overflow   = s_ff.ovf;
	// FIFO read port is a registered memory behind a pointer mux
	assign rd_valid   = fifo_out_valid;
	assign rd_data    = fifo_out_data;
endmodule : tern_master

// ===== tb/tern_master_props.sv
// Port assertions for the ternary link master.
// Assumes a slave that keeps the handover pattern and SYM_CYC of two.
module tern_master_props #(
	parameter int SYM_CYC = 2
) (
	input wire logic        clock,
	input wire logic        rstn,
	input wire logic        cmd_start,
	input wire logic        cmd_restart,
	input wire logic        cmd_read,
	input wire logic        cmd_ready,
	input wire logic        done,
	input wire logic        rd_valid,
	input wire logic        rd_ready,
	input wire logic [15:0] rd_data,
	input wire logic        parity_err,
	input wire logic        pair_err,
	input wire logic        sda_i,
	input wire logic        scl_o,
	input wire logic        scl_oe_n,
	input wire logic        sda_o,
	input wire logic        sda_oe_n
);
	timeunit 1ns;
	timeprecision 100ps;
	// ************************************************************
	// Properties
	// ************************************************************
	default clocking cb @(posedge clock); endclocking
	default disable iff (!rstn);
	sequence s_take;
		cmd_start && cmd_ready;
	endsequence
	sequence s_ref_hold;
		(!scl_o && sda_o) [*4];
	endsequence
	a_start_drive: assert property (s_take |=> !scl_oe_n && !sda_oe_n
		&& sda_o && scl_o == $past(cmd_restart) && !cmd_ready)
		else $error("command start left the lines wrong");
	a_first_hold: assert property ((s_take and !cmd_restart) |=>
		s_ref_hold)
		else $error("first command symbol came too early");
	a_restart_pulse: assert property ((s_take and cmd_restart) |=>
		scl_o [*2] ##1 s_ref_hold)
		else $error("restart clock pulse malformed");
	a_levels_stand: assert property (!scl_oe_n && $past(scl_oe_n) == 1'b0
		&& $changed({scl_o, sda_o}) |=> $stable({scl_o, sda_o}))
		else $error("symbol shorter than one tick");
	a_park_high: assert property ($rose(scl_oe_n) |->
		$past(scl_o) && $past(sda_o) && sda_oe_n)
		else $error("lines released without parking high");
	a_oe_pair: assert property (scl_oe_n == sda_oe_n)
		else $error("one line driven without the other");
	a_write_len: assert property ((s_take and !cmd_read) |->
		##[28:90] done)
		else $error("write command length wrong");
	a_take_low: assert property ($fell(sda_oe_n) && !sda_o |->
		!scl_o && !scl_oe_n && !$past(sda_i))
		else $error("bus taken back wrongly");
	a_err_pulse: assert property (parity_err || pair_err |=>
		!parity_err && !pair_err)
		else $error("error flag longer than one cycle");
	a_fifo_hold: assert property (rd_valid && !rd_ready |=>
		rd_valid && $stable(rd_data))
		else $error("read word changed while stalled");
endmodule : tern_master_props

bind tern_master tern_master_props #(.SYM_CYC(SYM_CYC)) props_u (
	.clock(clock), .rstn(rstn), .cmd_start(cmd_start),
	.cmd_restart(cmd_restart), .cmd_read(cmd_read), .cmd_ready(cmd_ready),
	.done(done), .rd_valid(rd_valid), .rd_ready(rd_ready), .rd_data(rd_data),
	.parity_err(parity_err), .pair_err(pair_err), .sda_i(sda_i),
	.scl_o(scl_o), .scl_oe_n(scl_oe_n), .sda_o(sda_o), .sda_oe_n(sda_oe_n));

// ===== tb/tern_slave_model.sv
// Behavioural slave: captures the command symbols and answers reads.
// Assumes the bench arms it once the start levels have settled.
module tern_slave_model #(
	parameter int SYM_CYC = 2
) (
	input  wire logic   clock,
	input  wire logic   scl,
	input  wire logic   sda,
	input  wire logic   legacy,
	output logic        s_scl,
	output logic        s_sda,
	output logic        s_oe,
	output logic [23:0] cmd_syms
);
	timeunit 1ns;
	timeprecision 100ps;
	// ************************************************************
	// Receive and answer
	// ************************************************************
	logic [23:0] txq[$];
	logic [1:0]  ref_l = 2'h1;
	logic [1:0]  sym;
	int          n_cap = 12;
	initial s_oe = 1'b0;
	initial cmd_syms = 24'h0;
	always @(posedge clock) begin
		if (n_cap < 12 && {scl, sda} != ref_l) begin
			sym = ~({scl, sda} ^ ref_l);
			ref_l = {scl, sda};
			if (!(legacy && sym == 2'h1 && !scl)) begin
				cmd_syms = {cmd_syms[21:0], sym};
				n_cap++;
			end
		end
	end
	task automatic arm();
		ref_l = {scl, sda};
		n_cap = 0;
	endtask : arm
	task automatic put(input logic c, input logic d);
		s_scl = c;
		s_sda = d;
		repeat (SYM_CYC) @(posedge clock);
		#2;
	endtask : put
	task automatic send(input logic [1:0] v);
		if (legacy && s_scl && v != 2'h0)
			put(1'b0, s_sda);
		put(s_scl ^ ~v[1], s_sda ^ ~v[0]);
	endtask : send
	// An empty queue refuses the read and goes straight to the end pattern
	task automatic respond(input int dly);
		logic [23:0] w;
		repeat (dly) @(posedge clock);
		#2;
		s_scl = 1'b1;
		s_sda = 1'b1;
		s_oe = 1'b1;
		while (txq.size() > 0) begin
			w = txq.pop_front();
			for (int i = 11; i >= 0; i--)
				send(w[2*i+:2]);
		end
		if (s_scl || !s_sda)
			put(1'b0, 1'b1);
		repeat (3) send(2'h2);
		// Overlap with the master driving low is legal, both pull low
		repeat (2) @(posedge clock);
		#2;
		s_oe = 1'b0;
	endtask : respond
endmodule : tern_slave_model

// ===== tb/tb_tern_master.sv
// Bench for the ternary master: random commands and read replies.
// Assumes the behavioural slave model and pull-ups on both lines.
module tb_tern_master import tern_pkg::*;;
	timeunit 1ns;
	timeprecision 100ps;
	logic        clock, rstn, cmd_start, cmd_restart, legacy, cmd_read;
	logic        rd_ready, cmd_ready, done, rd_valid, parity_err, pair_err;
	logic        overflow, scl_o, scl_oe_n, sda_o, sda_oe_n, s_scl, s_sda;
	logic        s_oe;
	logic [6:0]  cmd_code, cmd_addr;
	logic [15:0] rd_data;
	logic [15:0] rnd_st = 16'haada;
	logic [23:0] cmd_syms;
	logic [16:0] exp_q[$];
	int          fail_count = 0, num_checks = 0;
	int          n_done = 0, n_par = 0, n_pair = 0, n_ovf = 0;
	wire         scl = !scl_oe_n ? scl_o : (s_oe ? s_scl : 1'b1);
	wire         sda = !sda_oe_n ? sda_o : (s_oe ? s_sda : 1'b1);
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin fail_count++; \
	$display("wrong value at %0t: %h vs %h", $time, (a), (b)); end end

	tern_master #(.SYM_CYC(SYM_MIN_CYC), .DEPTH(FIFO_DEPTH)) dut_u (
		.clock(clock), .rstn(rstn), .cmd_start(cmd_start),
		.cmd_restart(cmd_restart), .ternary_legacy_tolerant_mode(legacy),
		.cmd_read(cmd_read), .cmd_code(cmd_code), .cmd_addr(cmd_addr),
		.cmd_ready(cmd_ready), .done(done), .rd_valid(rd_valid),
		.rd_ready(rd_ready), .rd_data(rd_data), .parity_err(parity_err),
		.pair_err(pair_err), .overflow(overflow), .scl_i(scl), .scl_o(scl_o),
		.scl_oe_n(scl_oe_n), .sda_i(sda), .sda_o(sda_o), .sda_oe_n(sda_oe_n));
	tern_slave_model #(.SYM_CYC(SYM_MIN_CYC)) slv (.clock(clock), .scl(scl),
		.sda(sda), .legacy(legacy), .s_scl(s_scl), .s_sda(s_sda),
		.s_oe(s_oe), .cmd_syms(cmd_syms));

	// ************************************************************
	// Clock, pulse counters and helpers
	// ************************************************************
	initial begin
		clock = 1'b0;
		forever #12.5 clock = ~clock;
	end
	// Pulses are counted here so none is lost while a task is blocked
	always @(posedge clock) begin
		n_done <= n_done + int'(done === 1'b1);
		n_par <= n_par + int'(parity_err === 1'b1);
		n_pair <= n_pair + int'(pair_err === 1'b1);
		n_ovf <= n_ovf + int'(overflow === 1'b1);
	end
	function automatic logic [15:0] lfsr();
		rnd_st = {rnd_st[14:0],
			rnd_st[15] ^ rnd_st[13] ^ rnd_st[12] ^ rnd_st[10]};
		return rnd_st;
	endfunction : lfsr
	function automatic logic [1:0] par(input logic [15:0] d);
		logic [1:0] p = 2'h0;
		for (int i = 0; i < 16; i += 2)
			p ^= {d[i+1], d[i]};
		return p;
	endfunction : par
	function automatic logic [23:0] enc(input logic [17:0] w);
		logic [23:0] s;
		int t;
		for (int i = 0; i < 6; i++) begin
			t = int'(w[17-3*i -: 3]);
			s[23-4*i -: 4] = {2'(t / 3), 2'(t % 3)};
		end
		return s;
	endfunction : enc
	task automatic conclude();
		if (fail_count == 0 && num_checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : conclude
	task automatic tick(input int n);
		repeat (n) @(posedge clock);
		#2;
	endtask : tick
	task automatic step(inout int lim);
		tick(1);
		lim++;
		if (lim > 3000) begin
			fail_count++;
			conclude();
		end
	endtask : step

	// ************************************************************
	// One command, with the slave reply and drain for reads
	// ************************************************************
	task automatic xfer(input logic rd, input logic rs, input int nw,
		input int bad);
		logic [15:0] cw, d;
		logic [23:0] s;
		int lim, b_done, b_par, b_pair, b_ovf;
		lim = 0;
		cw = lfsr();
		cw[15] = rd;
		cw[0] = 1'b0;
		{cmd_code, cmd_addr, cmd_restart, cmd_read} = {cw[14:1], rs, rd};
		while (cmd_ready !== 1'b1) step(lim);
		cmd_start = 1'b1;
		tick(1);
		cmd_start = 1'b0;
		tick(2);
		slv.arm();
		{b_done, b_par, b_pair, b_ovf} = {n_done, n_par, n_pair, n_ovf};
		if (!rd) begin
			while (n_done == b_done) step(lim);
		end else begin
			while (sda_oe_n !== 1'b1) step(lim);
			for (int j = 0; j < nw; j++) begin
				d = lfsr();
				s = enc({d, par(d) ^ {1'b0, bad == 1 && j == 0}});
				if (bad == 2 && j == 0)
					s[23:16] = 8'ha0;
				slv.txq.push_back(s);
				if (j < FIFO_DEPTH)
					exp_q.push_back({bad != 2 || j > 0, d});
			end
			slv.respond(int'(lfsr() % 16'h0020));
			while (n_done == b_done) step(lim);
			`CHK({scl_oe_n, sda_oe_n, scl_o, sda_o}, 4'h0)
			if (bad != 2) `CHK(n_par - b_par, int'(bad == 1))
			`CHK(n_pair - b_pair, int'(bad == 2))
			`CHK(n_ovf - b_ovf, int'(nw > FIFO_DEPTH))
			while (exp_q.size() > 0) begin
				d = lfsr();
				rd_ready = d[0];
				if (rd_valid === 1'b1 && d[0]) begin
					if (exp_q[0][16]) `CHK(rd_data, exp_q[0][15:0])
					void'(exp_q.pop_front());
				end
				step(lim);
			end
			rd_ready = 1'b0;
		end
		`CHK(cmd_syms, enc({cw, par(cw)}))
	endtask : xfer

	initial begin
		logic [15:0] t;
		{rstn, cmd_start, cmd_restart, legacy, cmd_read, rd_ready} = 6'h00;
		{cmd_code, cmd_addr} = 14'h0000;
		tick(6);
		rstn = 1'b1;
		for (int m = 0; m < 2; m++) begin
			legacy = m[0];
			xfer(1'b0, 1'b0, 0, 0);
			xfer(1'b0, 1'b1, 0, 0);
			xfer(1'b1, 1'b0, 0, 0);
			xfer(1'b1, 1'b1, 2, 1);
			xfer(1'b1, 1'b0, 2, 2);
			for (int r = 0; r < 6; r++) begin
				t = lfsr();
				xfer(t[0], t[1], int'(t[3:2]) + 1, 0);
			end
		end
		xfer(1'b1, 1'b1, FIFO_DEPTH + 1, 0);
		conclude();
	end
	// Full run needs some 2500 cycles; the limit allows over twenty times that
	initial begin
		#1500000;
		fail_count++;
		conclude();
	end
endmodule : tb_tern_master
